// [rtl/ppmc_pkg.sv]
// Constants and types shared by the power-management capability block.
package ppmc_pkg;

	// ----------------------------------------------------------------
	// Configuration access geometry
	// ----------------------------------------------------------------
	localparam int CFG_ADDR_W = 8;
	localparam int CFG_DATA_W = 32;
	localparam int CFG_BE_W   = 4;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses in configuration space)
	// ----------------------------------------------------------------
	localparam logic [7:0] CAPABILITY_IDENTIFIER_OFFSET     = 8'hDC;
	localparam logic [7:0] LINK_OFFSET       = 8'hDD;
	localparam logic [7:0] PWR_CAP_OFFSET    = 8'hDE;
	localparam logic [7:0] PWR_CTL_OFFSET    = 8'hE0;
	localparam logic [7:0] DWORD_ADDR_MASK   = 8'hFC;
	localparam int         LINK_LANE_LSB     = 8;
	localparam int         PWR_CAP_LANE_LSB  = 16;
	localparam int         PS_BYTE_LANE      = 0;

	// ----------------------------------------------------------------
	// Fixed values and field positions
	// ----------------------------------------------------------------
	localparam logic [7:0]  CAPABILITY_IDENTIFIER_VALUE       = 8'h01;
	localparam logic [7:0]  LINK_VALUE         = 8'h00;
	localparam logic [4:0]  WAKE_SUPPORT_VALUE = 5'h00;
	localparam logic [2:0]  VERSION_VALUE      = 3'h2;
	localparam int          WAKE_SUPPORT_LSB   = 11;
	localparam int          DEEP_STATE_BIT     = 10;
	localparam int          LIGHT_STATE_BIT    = 9;
	localparam int          DEV_INIT_BIT       = 5;
	localparam int          WAKE_CLK_BIT       = 3;
	localparam int          VERSION_LSB        = 0;
	localparam int          WAKE_STATUS_BIT    = 15;
	localparam int          WAKE_ENABLE_BIT    = 8;
	localparam int          PS_LSB             = 0;
	localparam int          PS_W               = 2;
	localparam logic [15:0] ZERO_HALF          = 16'h0000;
	localparam logic [31:0] ZERO_WORD          = 32'h0000_0000;

	// ----------------------------------------------------------------
	// Power state encoding
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PPMC_D0      = 2'b00,
		PPMC_D1_RSVD = 2'b01,
		PPMC_D2_RSVD = 2'b10,
		PPMC_D3HOT   = 2'b11
	} ppmc_pstate_e;

endpackage

// [rtl/ppmc_state_if.sv]
// Interface between the configuration decoder and the power-state holder.
`timescale 1ns/100ps
interface ppmc_state_if;
	import ppmc_pkg::*;

	logic         wr_en;     // Accepted write to the power state field.
	ppmc_pstate_e wr_state;  // Value written by the host.
	logic         flag_clr;  // Core clears the changed flag.
	ppmc_pstate_e state_q;   // Current power state.
	logic         flag_q;    // Sticky power-state-changed flag.

	modport owner (
		input  wr_en,
		input  wr_state,
		input  flag_clr,
		output state_q,
		output flag_q
	);

	modport user (
		output wr_en,
		output wr_state,
		output flag_clr,
		input  state_q,
		input  flag_q
	);
endinterface

// [rtl/ppmc_state_reg.sv]
// Power state field and its sticky change flag.
`timescale 1ns/100ps
module ppmc_state_reg (
	input  wire logic   core_clk,
	input  wire logic   reset,
	ppmc_state_if.owner st
);
	import ppmc_pkg::*;

	ppmc_pstate_e state_d;
	ppmc_pstate_e state_q;
	logic         flag_d;
	logic         flag_q;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Reserved codes are dropped so software never sees an unsupported state.
	always_comb begin
		state_d = state_q;
		if (st.wr_en && (st.wr_state == PPMC_D0 || st.wr_state == PPMC_D3HOT)) begin
			state_d = st.wr_state; // R10
		end
		// A change arriving with a clear still sets the flag, so no event is lost.
		flag_d = flag_q & ~st.flag_clr;
		if (state_d != state_q) begin
			flag_d = 1'b1; // R11
		end
	end

	// Registers with asynchronous reset.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= PPMC_D0; // R10
			flag_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			flag_q  <= flag_d;
		end
	end

	assign st.state_q = state_q;
	assign st.flag_q  = flag_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_state_moves;
		st.state_q != $past(st.state_q);
	endsequence

	property p_change_sets_flag;
		@(posedge core_clk) disable iff (reset)
		s_state_moves |-> st.flag_q;
	endproperty
	a_change_sets_flag: assert property (p_change_sets_flag) // R11
		else $error("state changed without setting the flag");

	property p_flag_needs_cause;
		@(posedge core_clk) disable iff (reset)
		$rose(st.flag_q) |-> st.state_q != $past(st.state_q);
	endproperty
	a_flag_needs_cause: assert property (p_flag_needs_cause) // R11
		else $error("flag rose without a state change");

	property p_reserved_ignored;
		@(posedge core_clk) disable iff (reset)
		(st.wr_en && (st.wr_state == PPMC_D1_RSVD || st.wr_state == PPMC_D2_RSVD))
			|=> $stable(st.state_q);
	endproperty
	a_reserved_ignored: assert property (p_reserved_ignored) // R10
		else $error("reserved power state was stored");

	property p_only_write_moves;
		@(posedge core_clk) disable iff (reset)
		!st.wr_en |=> $stable(st.state_q);
	endproperty
	a_only_write_moves: assert property (p_only_write_moves) // R17
		else $error("power state moved without a write");
endmodule // ppmc_state_reg

// [rtl/ppmc_top.sv]
// Power-management capability entry of the satellite configuration space.
//
// Contract
// R1 - Link pointer byte is read-only zero, ending the capability list.
// R2 - Five-bit wake support field reads fixed zero.
// R3 - Deep intermediate state support bit reads zero.
// R4 - Light state support bit reads zero.
// R5 - Device-specific initialization bit reads fixed zero.
// R6 - Wake-needs-bus-clock bit reads fixed zero.
// R7 - Three-bit interface version field reads fixed two.
// R8 - Wake event status bit reads zero and does nothing.
// R9 - Wake event enable bit reads zero and does nothing.
// R10 - Host selects power state in two-bit field; resets D0; 11 is D3hot.
// R11 - Any change of the power state sets the changed flag.
// R12 - The changed flag can raise a power-state interrupt to the core.
// R13 - Current power state is mirrored to a core-readable status field.
// R14 - Host reaches these registers only while in satellite mode.
// R15 - Capability identifier byte reads fixed 0x01.
// R16 - Reserved bits read zero; writes to them are ignored.
// R17 - Only host writes to the power state field alter stored state.
`timescale 1ns/100ps
module ppmc_top (
	input  wire logic                              core_clk,
	input  wire logic                              reset,
	input  wire logic                              satellite_mode,
	input  wire logic                              cfg_req,
	input  wire logic                              cfg_write,
	input  wire logic [ppmc_pkg::CFG_ADDR_W-1:0]   cfg_addr,
	input  wire logic [ppmc_pkg::CFG_BE_W-1:0]     cfg_byte_en,
	input  wire logic [ppmc_pkg::CFG_DATA_W-1:0]   cfg_wdata,
	output logic      [ppmc_pkg::CFG_DATA_W-1:0]   cfg_rdata,
	output logic                                   cfg_ack,
	input  wire logic                              flag_clear,
	input  wire logic                              irq_enable,
	output logic                                   power_state_changed_flag,
	output logic                                   power_state_irq,
	output logic      [ppmc_pkg::PS_W-1:0]         satellite_power_state
);
	import ppmc_pkg::*;

	ppmc_state_if st ();

	logic                  accept;
	logic                  hit_cap;
	logic                  hit_ctl;
	logic [CFG_DATA_W-1:0] cap_word;
	logic [CFG_DATA_W-1:0] ctl_word;
	logic [CFG_DATA_W-1:0] rdata_d;
	logic [CFG_DATA_W-1:0] rdata_q;
	logic                  ack_d;
	logic                  ack_q;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Configuration cycles are dword based, so the low address bits are ignored.
	function automatic logic ppmc_dword_hit(input logic [CFG_ADDR_W-1:0] addr,
		input logic [CFG_ADDR_W-1:0] base);
		ppmc_dword_hit = ((addr & DWORD_ADDR_MASK) == (base & DWORD_ADDR_MASK));
	endfunction

	// Outside satellite mode the host side is deaf: nothing is taken or answered.
	assign accept  = cfg_req & satellite_mode; // R14
	assign hit_cap = ppmc_dword_hit(cfg_addr, CAPABILITY_IDENTIFIER_OFFSET);
	assign hit_ctl = ppmc_dword_hit(cfg_addr, PWR_CTL_OFFSET);

	// ----------------------------------------------------------------
	// Read images
	// ----------------------------------------------------------------
	// Capability dword: identifier, link pointer and the fixed capability word.
	always_comb begin
		cap_word = ZERO_WORD; // R16
		cap_word[LINK_LANE_LSB-1:0] = CAPABILITY_IDENTIFIER_VALUE; // R15
		cap_word[LINK_LANE_LSB +: 8] = LINK_VALUE; // R1
		cap_word[PWR_CAP_LANE_LSB+WAKE_SUPPORT_LSB +: 5] = WAKE_SUPPORT_VALUE; // R2
		cap_word[PWR_CAP_LANE_LSB+DEEP_STATE_BIT] = 1'b0; // R3
		cap_word[PWR_CAP_LANE_LSB+LIGHT_STATE_BIT] = 1'b0; // R4
		cap_word[PWR_CAP_LANE_LSB+DEV_INIT_BIT] = 1'b0; // R5
		cap_word[PWR_CAP_LANE_LSB+WAKE_CLK_BIT] = 1'b0; // R6
		cap_word[PWR_CAP_LANE_LSB+VERSION_LSB +: 3] = VERSION_VALUE; // R7
	end

	// Control dword: only the power state is live; wake bits are tied low.
	always_comb begin
		ctl_word = ZERO_WORD; // R16
		ctl_word[WAKE_STATUS_BIT] = 1'b0; // R8
		ctl_word[WAKE_ENABLE_BIT] = 1'b0; // R9
		ctl_word[PS_LSB +: PS_W] = st.state_q; // R10
	end

	// ----------------------------------------------------------------
	// Access sequencing
	// ----------------------------------------------------------------
	// Every accepted cycle is answered one clock later; unmapped reads give zero.
	always_comb begin
		ack_d   = accept; // R14
		rdata_d = rdata_q;
		if (accept && !cfg_write) begin
			if (hit_cap) begin
				rdata_d = cap_word;
			end else if (hit_ctl) begin
				rdata_d = ctl_word;
			end else begin
				rdata_d = ZERO_WORD; // R16
			end
		end
	end

	// Answer registers.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ack_q   <= 1'b0;
			rdata_q <= ZERO_WORD;
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// Writes land only in byte lane zero of the control dword; all else is dropped.
	assign st.wr_en    = accept & cfg_write & hit_ctl & cfg_byte_en[PS_BYTE_LANE]; // R17
	assign st.wr_state = ppmc_pstate_e'(cfg_wdata[PS_LSB +: PS_W]); // R10
	assign st.flag_clr = flag_clear;

	ppmc_state_reg u_state (
		.core_clk (core_clk),
		.reset    (reset),
		.st       (st)
	);

	// ----------------------------------------------------------------
	// Core-side outputs
	// ----------------------------------------------------------------
	// The interrupt is a level that follows the sticky flag, gated by the core.
	assign power_state_changed_flag = st.flag_q; // R11
	assign power_state_irq          = st.flag_q & irq_enable; // R12
	assign satellite_power_state    = st.state_q; // R13
	assign cfg_rdata                = rdata_q;
	assign cfg_ack                  = ack_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_read_cap;
		cfg_req && satellite_mode && !cfg_write && hit_cap;
	endsequence

	sequence s_read_ctl;
		cfg_req && satellite_mode && !cfg_write && hit_ctl;
	endsequence

	property p_ack_follows;
		@(posedge core_clk) disable iff (reset)
		cfg_req && satellite_mode |=> cfg_ack;
	endproperty
	a_ack_follows: assert property (p_ack_follows) // R14
		else $error("accepted access not answered");

	property p_deaf_outside;
		@(posedge core_clk) disable iff (reset)
		!(cfg_req && satellite_mode) |=> !cfg_ack;
	endproperty
	a_deaf_outside: assert property (p_deaf_outside) // R14
		else $error("answer without accepted access");

	property p_cap_image;
		@(posedge core_clk) disable iff (reset)
		s_read_cap |=> cfg_rdata == 32'h0002_0001;
	endproperty
	a_cap_image: assert property (p_cap_image) // R7
		else $error("capability dword read wrong");

	property p_ctl_image;
		@(posedge core_clk) disable iff (reset)
		s_read_ctl |=> cfg_rdata == {30'h0000_0000, $past(satellite_power_state)};
	endproperty
	a_ctl_image: assert property (p_ctl_image) // R16
		else $error("control dword read wrong");

	property p_write_d3;
		@(posedge core_clk) disable iff (reset)
		(cfg_req && satellite_mode && cfg_write && hit_ctl && cfg_byte_en[0]
			&& cfg_wdata[1:0] == 2'b11) |=> satellite_power_state == 2'b11;
	endproperty
	a_write_d3: assert property (p_write_d3) // R10
		else $error("D3hot write not taken");

	property p_lane_ignored;
		@(posedge core_clk) disable iff (reset)
		(cfg_req && cfg_write && !cfg_byte_en[0]) |=> $stable(satellite_power_state);
	endproperty
	a_lane_ignored: assert property (p_lane_ignored) // R17
		else $error("write without lane zero altered state");

	property p_irq_level;
		@(posedge core_clk) disable iff (reset)
		power_state_irq == (power_state_changed_flag && irq_enable);
	endproperty
	a_irq_level: assert property (p_irq_level) // R12
		else $error("interrupt does not follow flag and enable");

	property p_flag_sticky;
		@(posedge core_clk) disable iff (reset)
		power_state_changed_flag && !flag_clear |=> power_state_changed_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) // R11
		else $error("changed flag dropped without a clear");

	property p_clear_works;
		@(posedge core_clk) disable iff (reset)
		flag_clear ##1 $stable(satellite_power_state) |-> !power_state_changed_flag;
	endproperty
	a_clear_works: assert property (p_clear_works) // R11
		else $error("changed flag survived a clear");
endmodule // ppmc_top

// [verif/pci_power_mgmt_capability_test.sv]
// Self-checking bench for the power-management capability block.
`timescale 1ns/100ps
module pci_power_mgmt_capability_test;
	import ppmc_pkg::*;

	logic                  core_clk, reset, satellite_mode, flag_clear, irq_enable;
	logic                  cfg_req, cfg_write, cfg_ack;
	logic                  power_state_changed_flag, power_state_irq;
	logic [CFG_ADDR_W-1:0] cfg_addr;
	logic [CFG_BE_W-1:0]   cfg_byte_en;
	logic [CFG_DATA_W-1:0] cfg_wdata, cfg_rdata;
	logic [PS_W-1:0]       satellite_power_state, exp_ps;
	logic                  exp_flag;
	int                    err_total = 0;
	int                    checks_done = 0;

	ppmc_top ppmc_top_i (
		.core_clk(core_clk), .reset(reset), .satellite_mode(satellite_mode),
		.cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
		.cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.cfg_ack(cfg_ack), .flag_clear(flag_clear), .irq_enable(irq_enable),
		.power_state_changed_flag(power_state_changed_flag),
		.power_state_irq(power_state_irq), .satellite_power_state(satellite_power_state)
	);

	ppmc_host_model ppmc_host_model_i (
		.core_clk(core_clk), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
		.cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
		.cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata)
	);

	// Free-running 50 MHz clock.
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// Expectations
	// ----------------------------------------------------------------
	// Read value of a dword; the capability word carries only version two.
	function automatic logic [31:0] exp_read(input logic [7:0] a, input logic [1:0] ps);
		if ((a & 8'hFC) == 8'hDC) return {16'h0002, 8'h00, 8'h01};
		if ((a & 8'hFC) == 8'hE0) return {30'h0, ps};
		return 32'h0000_0000;
	endfunction

	// Only D0 and D3hot written through lane zero of the control dword are kept.
	function automatic logic [1:0] exp_next(input logic [1:0] ps, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] wd);
		if ((a & 8'hFC) == 8'hE0 && be[0] && (wd[1:0] == 2'h0 || wd[1:0] == 2'h3)) return wd[1:0];
		return ps;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic stop_test();
		if (err_total == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One access with all its checks; a missing answer in satellite mode ends the run.
	task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] wd, input int gap);
		logic        acked;
		logic [31:0] rd;
		logic [1:0]  nxt;
		nxt = (wr && satellite_mode) ? exp_next(exp_ps, a, be, wd) : exp_ps;
		ppmc_host_model_i.access(wr, a, be, wd, gap, acked, rd);
		exp_flag = exp_flag | (nxt != exp_ps);
		exp_ps = nxt;
		check(acked, satellite_mode, "ack");
		if (acked && !wr) check(rd, exp_read(a, exp_ps), "rdata");
		check(satellite_power_state, exp_ps, "state");
		check(power_state_changed_flag, exp_flag, "flag");
		check(power_state_irq, exp_flag & irq_enable, "irq");
		if (satellite_mode && !acked) begin
			err_total++;
			stop_test();
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] tbl [8];
		logic [7:0] a;
		tbl = '{8'hDC, 8'hDD, 8'hDE, 8'hDF, 8'hE0, 8'hE2, 8'hE4, 8'h00};
		reset = 1'b1;
		satellite_mode = 1'b1;
		flag_clear = 1'b0;
		irq_enable = 1'b1;
		exp_ps = 2'h0;
		exp_flag = 1'b0;
		void'($urandom(32'hB14C));
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		reset = 1'b0;
		check(cfg_rdata, 32'h0000_0000, "reset rdata");
		foreach (tbl[i]) acc(1'b0, tbl[i], 4'hF, 32'h0000_0000, 0);
		acc(1'b1, 8'hDC, 4'hF, 32'hFFFF_FFFF, 0);
		acc(1'b1, 8'hE0, 4'hE, 32'hFFFF_FFFF, 1);
		acc(1'b1, 8'hE0, 4'hF, 32'hFFFF_FFFF, 0);
		acc(1'b0, 8'hDC, 4'hF, 32'h0000_0000, 0);
		acc(1'b0, 8'hE0, 4'hF, 32'h0000_0000, 0);
		// Every state code after a clear: reserved and repeated values leave the flag low.
		flag_clear = 1'b1;
		@(negedge core_clk);
		flag_clear = 1'b0;
		exp_flag = 1'b0;
		for (int v = 1; v < 5; v++) acc(1'b1, 8'hE0, 4'h1, 32'(v % 4), 0);
		// A change landing with a clear keeps the flag set.
		flag_clear = 1'b1;
		exp_flag = 1'b0;
		acc(1'b1, 8'hE0, 4'h1, 32'h0000_0003, 0);
		flag_clear = 1'b0;
		@(negedge core_clk);
		check(power_state_changed_flag, 1'b1, "set wins");
		satellite_mode = 1'b0;
		acc(1'b1, 8'hE0, 4'h1, 32'h0000_0000, 0);
		acc(1'b0, 8'hE0, 4'hF, 32'h0000_0000, 0);
		for (int k = 0; k < 120; k++) begin
			irq_enable = 1'($urandom);
			satellite_mode = ($urandom_range(7) != 0);
			if ($urandom_range(3) == 0) begin
				flag_clear = 1'b1;
				@(negedge core_clk);
				flag_clear = 1'b0;
				exp_flag = 1'b0;
			end
			a = ($urandom_range(4) == 0) ? 8'($urandom) : tbl[$urandom_range(7)];
			acc(1'($urandom), a, 4'($urandom), 32'($urandom), $urandom_range(2));
		end
		// A second reset in mid-run returns everything to its reset value.
		reset = 1'b1;
		@(negedge core_clk);
		reset = 1'b0;
		exp_ps = 2'h0;
		exp_flag = 1'b0;
		satellite_mode = 1'b1;
		check(cfg_ack, 1'b0, "reset ack");
		acc(1'b0, 8'hE0, 4'hF, 32'h0000_0000, 0);
		stop_test();
	end
endmodule // pci_power_mgmt_capability_test

// [verif/ppmc_host_model.sv]
// Host model that issues configuration cycles toward the capability block.
`timescale 1ns/100ps
module ppmc_host_model (
	input  wire logic                            core_clk,
	input  wire logic                            cfg_ack,
	input  wire logic [ppmc_pkg::CFG_DATA_W-1:0] cfg_rdata,
	output logic                                 cfg_req,
	output logic                                 cfg_write,
	output logic      [ppmc_pkg::CFG_ADDR_W-1:0] cfg_addr,
	output logic      [ppmc_pkg::CFG_BE_W-1:0]   cfg_byte_en,
	output logic      [ppmc_pkg::CFG_DATA_W-1:0] cfg_wdata
);
	import ppmc_pkg::*;

	// ----------------------------------------------------------------
	// Idle bus
	// ----------------------------------------------------------------
	// The strobe stays low until a task runs.
	initial begin
		cfg_req = 1'b0;
		cfg_write = 1'b0;
		cfg_addr = 8'h00;
		cfg_byte_en = 4'h0;
		cfg_wdata = 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// One access
	// ----------------------------------------------------------------
	// A one-cycle strobe, then a bounded wait for the answer; idle cycles before
	// the strobe model a slow host.
	task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
		input logic [31:0] wd, input int gap, output logic acked, output logic [31:0] rd);
		acked = 1'b0;
		rd = 32'h0000_0000;
		repeat (gap + 1) @(negedge core_clk);
		cfg_req = 1'b1;
		cfg_write = wr;
		cfg_addr = addr;
		cfg_byte_en = be;
		cfg_wdata = wd;
		@(negedge core_clk);
		cfg_req = 1'b0;
		// Released qualifiers flip, so a design that samples them late is caught.
		cfg_write = ~cfg_write;
		cfg_addr = ~cfg_addr;
		cfg_byte_en = ~cfg_byte_en;
		cfg_wdata = ~cfg_wdata;
		for (int n = 0; n < 4 && !acked; n++) begin
			if (cfg_ack === 1'b1) begin
				acked = 1'b1;
				rd = cfg_rdata;
			end else begin
				@(negedge core_clk);
			end
		end
	endtask
endmodule // ppmc_host_model
